// file: hw/cpu_regs_cfg.svh
// Constants for the addressing and fixed-point working register banks
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// ==========================================================
// Bank geometry
`define CFG_NREG      16
`define CFG_WIDTH     32
`define CFG_IDX_W     4
`define CFG_PAIR_W    64
`define CFG_SP_IDX    4'hf

// ==========================================================
// Reset value, stack step sizes and shift amount width
`define CFG_RESET_VAL 32'h0000_0000
`define CFG_STK_WORD  32'h0000_0004
`define CFG_STK_PAIR  32'h0000_0008
`define CFG_SHAMT_W   6

`endif

// file: hw/cpu_regs_pkg.sv
// Types shared by the working register banks
`default_nettype none
`include "cpu_regs_cfg.svh"
package cpu_regs_pkg;

    // ==========================================================
    // Enumerations
    typedef enum logic { BANK_ADDR = 1'b0, BANK_FIXED = 1'b1 } bank_e;

    typedef enum logic [2:0] {
        ALU_ADD   = 3'h0,
        MULTIPLY_OP = 3'h1,
        ALU_COMP  = 3'h2,
        ALU_SHIFT = 3'h3,
        ALU_AND   = 3'h4,
        ALU_OR    = 3'h5,
        ALU_XOR   = 3'h6
    } alu_op_e;

    typedef logic [`CFG_IDX_W-1:0] idx_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic                   en;
        logic                   pair;
        idx_t                   idx;
        logic [`CFG_PAIR_W-1:0] data;
    } wr_s;

    typedef struct packed {
        logic                   valid;
        bank_e                  bank;
        logic                   pair;
        idx_t                   idx;
        logic [`CFG_PAIR_W-1:0] data;
    } load_s;

    typedef struct packed {
        logic  valid;
        bank_e src_bank;
        bank_e dst_bank;
        logic  pair;
        idx_t  src;
        idx_t  dst;
    } move_s;

    typedef struct packed {
        logic    valid;
        bank_e   bank;
        logic    pair;
        alu_op_e op;
        idx_t    dst;
        idx_t    src_a;
        idx_t    src_b;
    } alu_s;

    typedef struct packed {
        logic  valid;
        bank_e bank;
        logic  pair;
        idx_t  idx;
    } store_s;

    typedef struct packed {
        logic                  valid;
        idx_t                  base;
        logic [`CFG_WIDTH-1:0] offset;
    } agen_s;

    typedef struct packed {
        logic valid;
        logic pop;
        logic wide;
    } stack_s;

endpackage : cpu_regs_pkg
`default_nettype wire

// file: hw/reg_bank.sv
// One bank of 32-bit working registers with a single or paired write
`include "cpu_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module reg_bank
    import cpu_regs_pkg::*;
#(
    parameter int            NREG   = `CFG_NREG,
    parameter int            WIDTH  = `CFG_WIDTH,
    parameter logic [3:0]    SP_IDX = `CFG_SP_IDX
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire wr_s                        wr,
    input  wire logic                       sp_en,
    input  wire logic [WIDTH-1:0]           sp_data,
    output var  logic [NREG-1:0][WIDTH-1:0] regs
);

    // ==========================================================
    // Storage; a pair writes low half to even, high half to odd
    // General write beats the stack adjust so an explicit load wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= `CFG_RESET_VAL;
            end
        end else begin
            if (sp_en) begin
                regs[SP_IDX] <= sp_data;
            end
            if (wr.en && wr.pair) begin
                regs[{wr.idx[3:1], 1'b0}] <= wr.data[WIDTH-1:0];
                regs[{wr.idx[3:1], 1'b1}] <= wr.data[2*WIDTH-1:WIDTH];
            end else if (wr.en) begin
                regs[wr.idx] <= wr.data[WIDTH-1:0];
            end
        end
    end

endmodule : reg_bank
`default_nettype wire

// file: hw/cpu_regs.sv
// Addressing and fixed-point working register banks of the core
// Operation
// - Sixteen 32-bit addressing registers, index 0-15
// - Addressing bank viewed as eight even pairs
// - Pairs serve 64-bit loads, stores, moves
// - Highest addressing register is stack pointer
// - Memory addresses come from addressing registers
// - Addressing registers feed multiply/add/compare/shift/logic
// - Sixteen 32-bit fixed-point registers, index 0-15
// - Fixed-point pairs serve 64-bit arithmetic, memory, moves
// - All registers clear to zero on reset
`include "cpu_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_regs
    import cpu_regs_pkg::*;
#(
    parameter int NREG  = `CFG_NREG,
    parameter int WIDTH = `CFG_WIDTH
) (
    input  wire logic                    CLOCK,
    input  wire logic                    RST_N,
    input  wire load_s                   LOAD,
    input  wire move_s                   MOVE,
    input  wire alu_s                    ALU,
    input  wire store_s                  STORE,
    input  wire agen_s                   AGEN,
    input  wire stack_s                  STACK,
    output var  logic [2*WIDTH-1:0]      STORE_DATA,
    output var  logic                    STORE_VALID,
    output var  logic [WIDTH-1:0]        MEM_ADDR,
    output var  logic                    ADDR_VALID,
    output var  logic                    ALU_FLAG,
    output var  logic [WIDTH-1:0]        SP_VALUE
);

    // ==========================================================
    // Banks
    logic [NREG-1:0][WIDTH-1:0] addr_reg;
    logic [NREG-1:0][WIDTH-1:0] fixed_reg;
    wr_s                        addr_wr;
    wr_s                        fixed_wr;
    logic [WIDTH-1:0]           next_sp;
    logic [WIDTH-1:0]           stk_step;

    reg_bank #(.NREG(NREG), .WIDTH(WIDTH), .SP_IDX(`CFG_SP_IDX)) u_addr (
        .clock   (CLOCK),
        .rst_n   (RST_N),
        .wr      (addr_wr),
        .sp_en   (STACK.valid),
        .sp_data (next_sp),
        .regs    (addr_reg)
    );

    // The fixed bank has no stack role, so its adjust port stays idle
    reg_bank #(.NREG(NREG), .WIDTH(WIDTH), .SP_IDX(`CFG_SP_IDX)) u_fixed (
        .clock   (CLOCK),
        .rst_n   (RST_N),
        .wr      (fixed_wr),
        .sp_en   (1'b0),
        .sp_data (`CFG_RESET_VAL),
        .regs    (fixed_reg)
    );

    // ==========================================================
    // Operand fetch; pair index forced even, odd half on top
    function automatic logic [2*WIDTH-1:0] fetch(
        input bank_e b,
        input logic  pair,
        input idx_t  idx
    );
        logic [NREG-1:0][WIDTH-1:0] r;
        r = (b == BANK_FIXED) ? fixed_reg : addr_reg;
        if (pair) begin
            fetch = {r[{idx[3:1], 1'b1}], r[{idx[3:1], 1'b0}]};
        end else begin
            fetch = {{WIDTH{1'b0}}, r[idx]};
        end
    endfunction : fetch

    // ==========================================================
    // Arithmetic on either bank, single or paired width
    logic [2*WIDTH-1:0] opa;
    logic [2*WIDTH-1:0] opb;
    logic [2*WIDTH-1:0] alu_res;
    logic               alu_wr;

    always_comb begin
        opa     = fetch(ALU.bank, ALU.pair, ALU.src_a);
        opb     = fetch(ALU.bank, ALU.pair, ALU.src_b);
        alu_wr  = ALU.valid && (ALU.op != ALU_COMP);
        alu_res = '0;
        case (ALU.op)
            ALU_ADD:     alu_res = opa + opb;
            MULTIPLY_OP: alu_res = opa * opb;
            ALU_SHIFT:   alu_res = opa << opb[`CFG_SHAMT_W-1:0];
            ALU_AND:     alu_res = opa & opb;
            ALU_OR:      alu_res = opa | opb;
            ALU_XOR:     alu_res = opa ^ opb;
            default:     alu_res = '0;
        endcase
        if (!ALU.pair) begin
            alu_res[2*WIDTH-1:WIDTH] = '0; // Single result keeps low word
        end
    end

    // ==========================================================
    // Write selection per bank: load over move over arithmetic
    // One write per bank per cycle keeps the banks single-ported
    logic [2*WIDTH-1:0] move_data;

    // A process, not an assign, so bank updates read by fetch retrigger it
    always_comb begin
        move_data = fetch(MOVE.src_bank, MOVE.pair, MOVE.src);
    end

    always_comb begin
        addr_wr  = '0;
        fixed_wr = '0;
        if (alu_wr) begin
            if (ALU.bank == BANK_FIXED) begin
                fixed_wr = '{1'b1, ALU.pair, ALU.dst, alu_res};
            end else begin
                addr_wr  = '{1'b1, ALU.pair, ALU.dst, alu_res};
            end
        end
        if (MOVE.valid) begin
            if (MOVE.dst_bank == BANK_FIXED) begin
                fixed_wr = '{1'b1, MOVE.pair, MOVE.dst, move_data};
            end else begin
                addr_wr  = '{1'b1, MOVE.pair, MOVE.dst, move_data};
            end
        end
        if (LOAD.valid) begin
            if (LOAD.bank == BANK_FIXED) begin
                fixed_wr = '{1'b1, LOAD.pair, LOAD.idx, LOAD.data};
            end else begin
                addr_wr  = '{1'b1, LOAD.pair, LOAD.idx, LOAD.data};
            end
        end
    end

    // ==========================================================
    // Stack pointer step: push uses then bumps, pop drops then uses
    assign stk_step = STACK.wide ? `CFG_STK_PAIR : `CFG_STK_WORD;
    assign next_sp  = STACK.pop ? addr_reg[`CFG_SP_IDX] - stk_step
                                : addr_reg[`CFG_SP_IDX] + stk_step;
    assign SP_VALUE = addr_reg[`CFG_SP_IDX];

    // ==========================================================
    // Memory address; stack traffic has priority over plain access
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            MEM_ADDR   <= `CFG_RESET_VAL;
            ADDR_VALID <= 1'b0;
        end else begin
            ADDR_VALID <= STACK.valid || AGEN.valid;
            if (STACK.valid) begin
                MEM_ADDR <= STACK.pop ? next_sp
                                      : addr_reg[`CFG_SP_IDX];
            end else if (AGEN.valid) begin
                MEM_ADDR <= addr_reg[AGEN.base] + AGEN.offset;
            end
        end
    end

    // ==========================================================
    // Store data, registered one cycle after the request
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            STORE_DATA  <= '0;
            STORE_VALID <= 1'b0;
        end else begin
            STORE_VALID <= STORE.valid;
            if (STORE.valid) begin
                STORE_DATA <= fetch(STORE.bank, STORE.pair, STORE.idx);
            end
        end
    end

    // ==========================================================
    // Compare flag: unsigned less-than, held until the next compare
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ALU_FLAG <= 1'b0;
        end else if (ALU.valid && ALU.op == ALU_COMP) begin
            ALU_FLAG <= (opa < opb);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    chk_reset_zero: assert property (
        $rose(RST_N) |-> (addr_reg == '0 && fixed_reg == '0))
        else $error("registers not cleared by reset");

    chk_pair_halves: assert property (
        (LOAD.valid && LOAD.pair && LOAD.bank == BANK_FIXED)
        |=> fixed_reg[{$past(LOAD.idx[3:1]), 1'b0}] == $past(LOAD.data[31:0])
         && fixed_reg[{$past(LOAD.idx[3:1]), 1'b1}]
            == $past(LOAD.data[63:32]))
        else $error("pair load halves misplaced");

    chk_single_keep: assert property (
        (LOAD.valid && !LOAD.pair && LOAD.bank == BANK_FIXED
         && LOAD.idx == 4'h2)
        |=> fixed_reg[3] == $past(fixed_reg[3]))
        else $error("single load disturbed neighbour");

    chk_store_pair: assert property (
        (STORE.valid && STORE.pair && STORE.bank == BANK_ADDR)
        |=> STORE_VALID ##0 STORE_DATA == {$past(addr_reg[{STORE.idx[3:1],
             1'b1}]), $past(addr_reg[{STORE.idx[3:1], 1'b0}])})
        else $error("pair store data wrong");

    chk_agen_addr: assert property (
        (AGEN.valid && !STACK.valid)
        |=> ADDR_VALID && MEM_ADDR == $past(addr_reg[AGEN.base] + AGEN.offset))
        else $error("generated address wrong");

    chk_sp_push: assert property (
        (STACK.valid && !STACK.pop && !STACK.wide && !LOAD.valid
         && !MOVE.valid && !ALU.valid)
        |=> SP_VALUE == $past(SP_VALUE) + 32'h4
            ##0 MEM_ADDR == $past(SP_VALUE))
        else $error("push did not step stack pointer");

    chk_sp_pop_back: assert property (
        (STACK.valid && STACK.pop && STACK.wide && !LOAD.valid
         && !MOVE.valid && !ALU.valid)
        |=> SP_VALUE == $past(SP_VALUE) - 32'h8 ##0 MEM_ADDR == SP_VALUE)
        else $error("pop did not step stack pointer");

    chk_move_copy: assert property (
        (MOVE.valid && !LOAD.valid && !MOVE.pair
         && MOVE.dst_bank == BANK_FIXED)
        |=> fixed_reg[$past(MOVE.dst)] == $past(move_data[31:0]))
        else $error("move did not copy");

    chk_add_pair: assert property (
        (ALU.valid && ALU.op == ALU_ADD && ALU.pair && ALU.bank == BANK_ADDR
         && !LOAD.valid && !MOVE.valid && !STACK.valid)
        |=> {addr_reg[{$past(ALU.dst[3:1]), 1'b1}],
             addr_reg[{$past(ALU.dst[3:1]), 1'b0}]} == $past(opa + opb))
        else $error("pair add result wrong");

    chk_addr_idle: assert property (
        (!AGEN.valid && !STACK.valid) |=> !ADDR_VALID)
        else $error("address valid without request");

    cov_pair_load: cover property (LOAD.valid && LOAD.pair);
    cov_push_pop:  cover property (STACK.valid && !STACK.pop
                                   ##1 STACK.valid && STACK.pop);
    cov_multiply:  cover property (ALU.valid && ALU.op == MULTIPLY_OP);
    cov_agen:      cover property (AGEN.valid ##1 ADDR_VALID);

endmodule : cpu_regs
`default_nettype wire

// file: test/exec_model.sv
// Request model of the execute units that drive the register banks
`timescale 1ns/1ps
`default_nettype none
module exec_model
    import cpu_regs_pkg::*;
(
    input  wire logic   clock,
    output var  load_s  load,
    output var  move_s  move,
    output var  alu_s   alu,
    output var  store_s store,
    output var  agen_s  agen,
    output var  stack_s stack
);
    // ==========================================================
    // Idle requests
    // All requests idle from time zero so no port starts unknown
    initial begin
        load = '0;
        move = '0;
        alu = '0;
        store = '0;
        agen = '0;
        stack = '0;
    end

    // ==========================================================
    // One-cycle requests
    // Each request stands one cycle and is cleared at its taking edge,
    // so back-to-back calls leave an idle cycle between them
    task automatic do_load(input bank_e b, input logic p, input idx_t i,
                           input logic [63:0] d);
        @(posedge clock);
        load <= {1'b1, b, p, i, d};
        @(posedge clock);
        load <= '0;
    endtask : do_load

    task automatic do_move(input bank_e sb, input bank_e db, input logic p,
                           input idx_t s, input idx_t d);
        @(posedge clock);
        move <= {1'b1, sb, db, p, s, d};
        @(posedge clock);
        move <= '0;
    endtask : do_move

    task automatic do_alu(input bank_e b, input logic p, input alu_op_e op,
                          input idx_t d, input idx_t a, input idx_t s);
        @(posedge clock);
        alu <= {1'b1, b, p, op, d, a, s};
        @(posedge clock);
        alu <= '0;
    endtask : do_alu

    task automatic do_store(input bank_e b, input logic p, input idx_t i);
        @(posedge clock);
        store <= {1'b1, b, p, i};
        @(posedge clock);
        store <= '0;
    endtask : do_store

    task automatic do_agen(input idx_t base, input logic [31:0] off);
        @(posedge clock);
        agen <= {1'b1, base, off};
        @(posedge clock);
        agen <= '0;
    endtask : do_agen

    task automatic do_stack(input logic pop, input logic wide);
        @(posedge clock);
        stack <= {1'b1, pop, wide};
        @(posedge clock);
        stack <= '0;
    endtask : do_stack
endmodule : exec_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking testbench for the working register banks
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cpu_regs_pkg::*;
;
    logic        clock;
    logic        rst_n;
    load_s       load;
    move_s       move;
    alu_s        alu;
    store_s      store;
    agen_s       agen;
    stack_s      stack;
    logic [63:0] store_data;
    logic        store_valid;
    logic [31:0] mem_addr;
    logic        addr_valid;
    logic        alu_flag;
    logic [31:0] sp_value;
    int          err_total = 0;
    int          n_checks = 0;

    // ==========================================================
    // Clock, design and request model
    initial clock = 1'b0;
    always #4 clock = ~clock;

    cpu_regs dut_u (.CLOCK(clock), .RST_N(rst_n), .LOAD(load), .MOVE(move),
        .ALU(alu), .STORE(store), .AGEN(agen), .STACK(stack),
        .STORE_DATA(store_data), .STORE_VALID(store_valid),
        .MEM_ADDR(mem_addr), .ADDR_VALID(addr_valid),
        .ALU_FLAG(alu_flag), .SP_VALUE(sp_value));

    exec_model exec_u (.clock(clock), .load(load), .move(move), .alu(alu),
        .store(store), .agen(agen), .stack(stack));

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic store_chk(input bank_e b, input logic p, input idx_t i,
                             input logic [63:0] exp);
        exec_u.do_store(b, p, i);
        #1;
        check(64'(store_valid), 64'h1);
        check(store_data, exp);
    endtask : store_chk

    task automatic addr_chk(input logic [31:0] addr, input logic [31:0] sp);
        check(64'(addr_valid), 64'h1);
        check(64'(mem_addr), {32'h0, addr});
        check(64'(sp_value), {32'h0, sp});
    endtask : addr_chk

    // Distinct per register and per bank, so aliasing shows up
    function automatic logic [31:0] pattern(input int b, input int i);
        return (32'h0101_0101 * 32'(i + 1)) ^ (b != 0 ? 32'hffff_0000 : 32'h0);
    endfunction : pattern

    // ==========================================================
    // Scenarios
    task automatic do_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic zero_chk;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 16; i++) begin
                store_chk(bank_e'(b), 1'b0, idx_t'(i), 64'h0);
            end
        end
        check(64'(sp_value), 64'h0);
    endtask : zero_chk

    // Write everything first, then read back, to catch shared storage
    task automatic fill_chk;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 16; i++) begin
                exec_u.do_load(bank_e'(b), 1'b0, idx_t'(i),
                               {32'h0, pattern(b, i)});
            end
        end
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 16; i++) begin
                store_chk(bank_e'(b), 1'b0, idx_t'(i),
                          {32'h0, pattern(b, i)});
            end
        end
    endtask : fill_chk

    task automatic pair_chk;
        exec_u.do_load(BANK_ADDR, 1'b1, 4'h5, 64'hdead_beef_0123_4567);
        store_chk(BANK_ADDR, 1'b0, 4'h4, 64'h0000_0000_0123_4567);
        store_chk(BANK_ADDR, 1'b0, 4'h5, 64'h0000_0000_dead_beef);
        store_chk(BANK_ADDR, 1'b1, 4'h4, 64'hdead_beef_0123_4567);
        exec_u.do_move(BANK_ADDR, BANK_FIXED, 1'b1, 4'h4, 4'he);
        store_chk(BANK_FIXED, 1'b1, 4'he, 64'hdead_beef_0123_4567);
        store_chk(BANK_FIXED, 1'b0, 4'hf, 64'h0000_0000_dead_beef);
        exec_u.do_move(BANK_ADDR, BANK_FIXED, 1'b0, 4'h5, 4'h1);
        store_chk(BANK_FIXED, 1'b0, 4'h1, 64'h0000_0000_dead_beef);
    endtask : pair_chk

    task automatic alu_chk;
        logic [31:0] exp [7] = '{32'h8000_0008, 32'h8000_000f, 32'h0,
            32'h0000_0060, 32'h1, 32'h8000_0007, 32'h8000_0006};
        exec_u.do_load(BANK_ADDR, 1'b0, 4'h1, 64'h8000_0003);
        exec_u.do_load(BANK_ADDR, 1'b0, 4'h2, 64'h5);
        for (int k = 0; k < 7; k++) begin
            if (k == 2) continue;
            exec_u.do_alu(BANK_ADDR, 1'b0, alu_op_e'(k), 4'h3, 4'h1, 4'h2);
            store_chk(BANK_ADDR, 1'b0, 4'h3, {32'h0, exp[k]});
        end
        exec_u.do_alu(BANK_ADDR, 1'b0, ALU_COMP, 4'h3, 4'h1, 4'h2);
        #1;
        check(64'(alu_flag), 64'h0);
        exec_u.do_alu(BANK_ADDR, 1'b0, ALU_COMP, 4'h3, 4'h2, 4'h1);
        #1;
        check(64'(alu_flag), 64'h1);
        // Carry must cross from the even half into the odd half
        for (int b = 0; b < 2; b++) begin
            exec_u.do_load(bank_e'(b), 1'b1, 4'h0, 64'h0000_0001_ffff_ffff);
            exec_u.do_load(bank_e'(b), 1'b1, 4'h2, 64'h1);
            exec_u.do_alu(bank_e'(b), 1'b1, ALU_ADD, 4'h4, 4'h0, 4'h2);
            store_chk(bank_e'(b), 1'b1, 4'h4,
                      64'h0000_0002_0000_0000);
        end
    endtask : alu_chk

    task automatic stack_chk;
        exec_u.do_stack(1'b0, 1'b0);
        #1;
        addr_chk(32'h0, 32'h4);
        exec_u.do_stack(1'b0, 1'b1);
        #1;
        addr_chk(32'h4, 32'hc);
        exec_u.do_stack(1'b0, 1'b1);
        #1;
        addr_chk(32'hc, 32'h14);
        exec_u.do_stack(1'b1, 1'b1);
        #1;
        addr_chk(32'hc, 32'hc);
        exec_u.do_stack(1'b1, 1'b0);
        #1;
        addr_chk(32'h8, 32'h8);
        @(posedge clock);
        #1;
        check(64'(addr_valid), 64'h0);
        store_chk(BANK_ADDR, 1'b0, 4'hf, 64'h8);
        exec_u.do_load(BANK_ADDR, 1'b0, 4'hf, 64'h100);
        #1;
        check(64'(sp_value), 64'h100);
        // Address arithmetic wraps within the 32-bit space
        exec_u.do_load(BANK_ADDR, 1'b0, 4'h7, 64'hffff_fff0);
        exec_u.do_agen(4'h7, 32'h0000_0020);
        #1;
        addr_chk(32'h0000_0010, 32'h100);
    endtask : stack_chk

    // ==========================================================
    // Verdict, watchdog and main sequence
    task automatic complete_run;
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        do_reset();
        zero_chk();
        fill_chk();
        do_reset();
        zero_chk();
        pair_chk();
        alu_chk();
        stack_chk();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
